// ===== hdl/eirl_pin_sync.v
`timescale 1ns/1ns
`default_nettype none
`include "eirl_defines.vh"

// Shift chain synchroniser for the asynchronous request pin.
// Resets to the idle (high) level so no false edge follows reset.
module eirl_pin_sync #(
    parameter STAGES = `EIRL_SYNC_STAGES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire pin_async,
    output wire pin_sync
);
    // Only the last stage leaves the chain; STAGES must be 2 or more
    reg [STAGES-1:0] chain_reg;
    wire [STAGES-1:0] chain_next;

    assign chain_next = {chain_reg[STAGES-2:0], pin_async};

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            chain_reg <= {STAGES{`EIRL_PIN_IDLE}};
        end else begin
            chain_reg <= chain_next;
        end
    end

    assign pin_sync = chain_reg[STAGES-1];
endmodule // eirl_pin_sync

`default_nettype wire

// ===== hdl/eirl_request_latch.v
`timescale 1ns/1ns
`default_nettype none
`include "eirl_defines.vh"

// Contract
// - Low request on pin sets pending latch
// - Never respond mid-instruction; await completion
// - At boundary, pending and mask clear: enter
// - Option bit picks edge or edge-and-level
// - Pin raises requests only in user mode
// - Logic runs on oscillator-divided-by-two bus clock
module eirl_request_latch #(
    parameter SYNC_STAGES = `EIRL_SYNC_STAGES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire irq_pin_n,
    input wire level_sense,
    input wire user_mode,
    input wire insn_done,
    input wire int_mask,
    input wire entry_ack,
    output reg irq_pending,
    output reg irq_entry
);
    // sys_clk is the bus clock: bus_clock_frequency is
    // oscillator_frequency divided by EIRL_BUS_CLK_DIV.

    // ************************************************
    // Sequencer state codes
    // ************************************************
    // Binary coded; the two spare codes fall back to idle
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ENTRY = 2'h1;

    // ************************************************
    // Helper functions
    // ************************************************
    // High for one cycle when the synchronised pin falls
    function edge_seen;
        input prev_level;
        input cur_level;
        begin
            edge_seen = prev_level & ~cur_level;
        end
    endfunction

    // Request seen under the chosen sensitivity
    function sense_request;
        input edge_hit;
        input cur_level;
        input level_mode;
        begin
            sense_request = edge_hit | (level_mode & ~cur_level);
        end
    endfunction

    // Entry is only taken at a boundary with the mask clear
    function take_entry;
        input boundary;
        input pending;
        input masked;
        begin
            take_entry = boundary & pending & ~masked;
        end
    endfunction

    // ************************************************
    // Pin synchronisation
    // ************************************************
    // A low pulse shorter than one sys_clk period may be missed;
    // a requester must hold the pin low at least that long.
    wire pin_sync;

    eirl_pin_sync #(
        .STAGES(SYNC_STAGES)
    ) i_eirl_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_async(irq_pin_n),
        .pin_sync(pin_sync)
    );

    // ************************************************
    // Edge detection
    // ************************************************
    reg pin_prev_reg;
    reg pin_prev_next;
    wire fall_edge;

    always @* begin
        pin_prev_next = pin_sync;
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            // Idle level, so releasing reset is not an edge
            pin_prev_reg <= `EIRL_PIN_IDLE;
        end else begin
            pin_prev_reg <= pin_prev_next;
        end
    end

    // Edge mode sees a held-low pin only once
    assign fall_edge = edge_seen(pin_prev_reg, pin_sync);

    // ************************************************
    // Sensitivity and mode gating
    // ************************************************
    wire sense_hit;
    wire raise_req;

    assign sense_hit = sense_request(fall_edge, pin_sync, level_sense);

    // gate by user mode
    // Bootloader mode uses the pin as a supply, not a request
    assign raise_req = user_mode & sense_hit;

    // ************************************************
    // Boundary decode
    // ************************************************
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg entry_next;
    reg pend_next;
    wire boundary_take;
    wire entry_done;

    assign boundary_take = take_entry(insn_done, irq_pending, int_mask);

    // An acknowledge outside an entry is ignored
    assign entry_done = (state_reg == ST_ENTRY) & entry_ack;

    // ************************************************
    // Entry sequencer
    // ************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (boundary_take) begin
                    state_next = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                // Entry stands until the core takes it
                if (entry_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                // Recover from a spare code
                state_next = ST_IDLE;
            end
        endcase
    end

    // Entry request is the next state decoded ahead of its register
    always @* begin
        if (state_next == ST_ENTRY) begin
            entry_next = 1'b1;
        end else begin
            entry_next = 1'b0;
        end
    end

    // ************************************************
    // Pending latch
    // ************************************************
    // Kept through masked boundaries until an entry is taken
    always @* begin
        pend_next = irq_pending;
        if (entry_done) begin
            pend_next = 1'b0;
        end
        // latch request, set wins over clear
        if (raise_req) begin
            pend_next = 1'b1;
        end
    end

    // ************************************************
    // State register
    // ************************************************
    // bus clock domain
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************
    // Output registers
    // ************************************************
    // Both outputs come straight from flip-flops
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_pending <= `EIRL_PEND_RST;
        end else begin
            irq_pending <= pend_next;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_entry <= 1'b0;
        end else begin
            irq_entry <= entry_next;
        end
    end
endmodule // eirl_request_latch

`default_nettype wire

// ===== include/eirl_defines.vh
`ifndef EIRL_DEFINES_VH
`define EIRL_DEFINES_VH

// Oscillator to bus clock divide ratio
`define EIRL_BUS_CLK_DIV 2
// Synchroniser depth
`define EIRL_SYNC_STAGES 2
// Reset values
`define EIRL_PEND_RST 1'b0
`define EIRL_PIN_IDLE 1'b1

`endif

// ===== verification/eirl_irq_source.sv
`timescale 1ns/1ns
`default_nettype none
// Pulled-up request line, low only while a request is wanted
module eirl_irq_source (
output var logic irq_pin_n
);
initial irq_pin_n = 1'h1;
task set_pin(input logic v);
irq_pin_n <= v;
endtask
endmodule // eirl_irq_source
`default_nettype wire

// ===== verification/eirl_request_latch_bench.sv
`timescale 1ns/1ns
`default_nettype none
module eirl_request_latch_bench;
logic sys_clk = 1'h0, rst_n = 1'h0, lvl = 1'h0, usr = 1'h1;
logic done = 1'h0, msk = 1'h1, ack = 1'h0;
wire pin_n, pend, entry;
int fails = 0, checks_done = 0, cyc = 0;
always #50 sys_clk = ~sys_clk;
eirl_irq_source i_eirl_irq_source (.irq_pin_n(pin_n));
eirl_request_latch i_eirl_request_latch (.sys_clk(sys_clk), .rst_n(rst_n),
.irq_pin_n(pin_n), .level_sense(lvl), .user_mode(usr), .insn_done(done),
.int_mask(msk), .entry_ack(ack), .irq_pending(pend), .irq_entry(entry));
task chk(input logic s, e);
checks_done++;
if (s !== e) $display("FAIL %0t mismatch", $time);
if (s !== e) fails++;
endtask
task step(input int n);
repeat (n) @(posedge sys_clk);
#1;
endtask
task pin(input logic v);
@(posedge sys_clk) i_eirl_irq_source.set_pin(v);
endtask
// Pulse a boundary, or an entry acknowledge when a is set
task cpu(input bit a);
@(posedge sys_clk) if (a) ack <= 1'h1; else done <= 1'h1;
@(posedge sys_clk) {ack, done} <= 2'h0;
step(1);
endtask
task t_boot;
@(posedge sys_clk) usr <= 1'h0;
pin(1'h0);
step(6);
chk(pend, 1'h0);
pin(1'h1);
@(posedge sys_clk) usr <= 1'h1;
$display("boot done");
endtask
task t_edge;
pin(1'h0);
step(5);
chk(pend, 1'h1);
cpu(1'h0);
chk(entry, 1'h0);
@(posedge sys_clk) msk <= 1'h0;
step(3);
chk(entry, 1'h0);
cpu(1'h0);
chk(entry, 1'h1);
cpu(1'h1);
chk(pend, 1'h0);
pin(1'h1);
$display("edge done");
endtask
task t_level;
@(posedge sys_clk) lvl <= 1'h1;
pin(1'h0);
step(5);
cpu(1'h0);
cpu(1'h1);
chk(pend, 1'h1);
pin(1'h1);
step(4);
cpu(1'h0);
cpu(1'h1);
chk(pend, 1'h0);
$display("level done");
endtask
task report_and_stop;
$display("checks %0d fails %0d", checks_done, fails);
if (fails == 0 && checks_done > 0) $display("STATUS OK");
else $display("STATUS NOT OK");
$finish;
endtask
always @(posedge sys_clk) begin
cyc <= cyc + 1;
if (cyc == 300) begin
fails++;
report_and_stop;
end
end
initial begin
repeat (12) @(posedge sys_clk);
rst_n <= 1'h1;
t_boot;
t_edge;
t_level;
report_and_stop;
end
endmodule // eirl_request_latch_bench
bind eirl_request_latch eirl_sva i_eirl_sva (
.sys_clk(sys_clk),
.rst_n(rst_n),
.irq_pin_n(irq_pin_n),
.level_sense(level_sense),
.user_mode(user_mode),
.insn_done(insn_done),
.int_mask(int_mask),
.entry_ack(entry_ack),
.irq_pending(irq_pending),
.irq_entry(irq_entry)
);
`default_nettype wire

// ===== verification/eirl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module eirl_sva (
input wire sys_clk,
input wire rst_n,
input wire irq_pin_n,
input wire level_sense,
input wire user_mode,
input wire insn_done,
input wire int_mask,
input wire entry_ack,
input wire irq_pending,
input wire irq_entry
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_n);
sequence s_take;
insn_done && irq_pending && !int_mask && !irq_entry;
endsequence
sequence s_boot_idle; !user_mode && !irq_pending; endsequence
a_entry_taken: assert property (s_take |=> irq_entry)
else $error("missed");
a_no_mid_insn: assert property ($rose(irq_entry) |-> $past(insn_done))
else $error("early");
a_pin_latched: assert property (
$fell(irq_pin_n) && user_mode |-> ##[3:4] irq_pending) else $error("lost");
a_ack_clears: assert property (
entry_ack && !insn_done |=> !irq_entry) else $error("stuck");
a_level_holds: assert property (
(level_sense && user_mode && !irq_pin_n)[*4] |=> irq_pending)
else $error("dropped");
a_boot_no_set: assert property (s_boot_idle |=> !irq_pending)
else $error("boot set");
a_entry_gated: assert property ($rose(irq_entry) |->
$past(irq_pending) && !$past(int_mask)) else $error("masked");
endmodule // eirl_sva
`default_nettype wire
